// ---- rtl/atx_top.sv ----
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
module atx_top
  import atx_pkg::*;
#(
  parameter int DATA_W = SLOT_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [DATA_W-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic rx_tag_valid,
  input wire logic [NSLOT-1:0] rx_tag_req,
  input wire logic cmd_req,
  input wire logic cmd_read,
  input wire logic [6:0] cmd_index,
  input wire logic [15:0] cmd_wdata,
  input wire logic cmd_pdown,
  output logic cmd_sent,
  output logic link_bclk,
  output logic link_sync,
  output logic link_sdout
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0] bclk_cfg;
  logic [31:0] tx_frame;
  logic [31:0] link_slot;
  logic [1:0] attached_device_number;
  logic [NSLOT-1:0] slot_en;
  logic vra_en;
  logic warm_active;
  logic [6:0] warm_cnt;
  atx_state_e state;
  logic [NSLOT-1:0] active;
  logic [NSLOT-1:0] tag_req;

  assign attached_device_number = link_slot[ID_LSB +: 2];
  assign slot_en = link_slot[SLOT_EN_LSB +: NSLOT];
  assign vra_en = link_slot[VRA_BIT];
  assign warm_active = link_slot[WARM_BIT];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bclk_cfg <= REG_RESET;
      tx_frame <= REG_RESET;
    end else if (wr) begin
      if (addr == ADDR_BCLK_CFG) begin
        bclk_cfg <= wdata & BCLK_MASK;
      end else if (addr == ADDR_TX_FRAME) begin
        tx_frame <= wdata & TX_FRAME_MASK;
      end
    end
  end

  // Warm bit is only set by software and only cleared by the timer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link_slot <= REG_RESET;
    end else begin
      if (wr && addr == ADDR_LINK_SLOT) begin
        link_slot[15:14] <= wdata[15:14];
        link_slot[12:0] <= wdata[12:0] & LINK_SLOT_MASK[12:0];
        if (wdata[WARM_BIT]) begin
          link_slot[WARM_BIT] <= 1'b1;
        end
      end
      if (warm_active && warm_cnt == 7'(WARM_CYC - 1)) begin
        link_slot[WARM_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      if (addr == ADDR_BCLK_CFG) begin
        rdata <= bclk_cfg;
      end else if (addr == ADDR_TX_FRAME) begin
        rdata <= tx_frame;
      end else if (addr == ADDR_LINK_SLOT) begin
        rdata <= link_slot;
      end else if (addr == ADDR_TX_STATUS) begin
        rdata <= {20'h00000, state == ATX_OFF, 1'b0, active};
      end else begin
        rdata <= 32'h0000_0000;
      end
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Warm reset timer
  // ----------------------------------------
  // Runs on clk because the bit clock is stopped while powered down
  always_ff @(posedge clk) begin
    if (!rst_n || !warm_active) begin
      warm_cnt <= 7'h00;
    end else begin
      warm_cnt <= warm_cnt + 7'h01;
    end
  end

  // ----------------------------------------
  // Frame timing
  // ----------------------------------------
  atx_frame_if fr ();
  logic bclk_int;

  assign fr.run = (state != ATX_OFF) && !warm_active;

  atx_bclk_div u_div (
    .clk(clk),
    .rst_n(rst_n),
    .div(bclk_cfg[15:0]),
    .fr(fr),
    .bclk(bclk_int)
  );

  atx_fsync_gen u_gen (
    .clk(clk),
    .rst_n(rst_n),
    .period(tx_frame[15:0]),
    .width(tx_frame[WIDTH_LSB +: 8]),
    .dly(tx_frame[DLY_LSB +: 7]),
    .fr(fr)
  );

  // ----------------------------------------
  // Command and request capture
  // ----------------------------------------
  logic cmd_pend;
  logic cmd_frame;
  logic cmd_rd_q;
  logic pdown_frame;
  logic [6:0] cmd_idx_q;
  logic [15:0] cmd_wd_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_pend <= 1'b0;
      cmd_rd_q <= 1'b0;
      cmd_idx_q <= 7'h00;
      cmd_wd_q <= 16'h0000;
    end else if (cmd_req) begin
      cmd_pend <= 1'b1;
      cmd_rd_q <= cmd_read;
      cmd_idx_q <= cmd_index;
      cmd_wd_q <= cmd_wdata;
    end else if (fr.data_start && state != ATX_OFF) begin
      cmd_pend <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tag_req <= '0;
    end else if (rx_tag_valid) begin
      tag_req <= rx_tag_req;
    end
  end

  // ----------------------------------------
  // Slot selection
  // ----------------------------------------
  logic [NSLOT-1:0] next_active;
  always_comb begin
    if (!vra_en) begin
      next_active = slot_en;
    end else if ((tag_req & slot_en) == slot_en) begin
      next_active = tag_req;
    end else begin
      next_active = '0;
    end
  end

  // ----------------------------------------
  // Serializer
  // ----------------------------------------
  logic [SLOT_W-1:0] sr;
  logic [3:0] slot_idx;
  logic [4:0] slot_bit;
  logic last_bit;
  logic [3:0] nslot;
  logic take;
  logic [TAG_W-1:0] tag;

  assign last_bit = slot_bit ==
    ((slot_idx == 4'h0) ? TAG_LAST_BIT : SLOT_LAST_BIT);
  assign nslot = slot_idx + 4'h1;
  // Sample order is assumed to follow the codec request order
  assign take = (state == ATX_SEND) && fr.bit_tick && last_bit &&
    nslot >= FIRST_DATA_SLOT && nslot <= LAST_SLOT &&
    active[nslot - FIRST_DATA_SLOT];
  assign tx_ready = take;
  assign tag = {(|next_active) || cmd_pend, cmd_pend, cmd_pend && !cmd_rd_q,
    next_active[0], next_active[1], next_active[2], next_active[3],
    next_active[4], next_active[5], next_active[6], next_active[7],
    next_active[8], next_active[9], 1'b0, attached_device_number};

  function automatic logic [SLOT_W-1:0] slot_word(input logic [3:0] s,
      input logic ok);
    logic [SLOT_W-1:0] w;
    w = '0;
    if (s == 4'h1 && cmd_frame) begin
      w = {cmd_rd_q, cmd_idx_q, 12'h000};
    end else if (s == 4'h2 && cmd_frame && !cmd_rd_q) begin
      w = {cmd_wd_q, 4'h0};
    end else if (ok) begin
      w = tx_data[SLOT_W-1:0];
    end
    return w;
  endfunction

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ATX_IDLE;
      sr <= '0;
      slot_idx <= 4'h0;
      slot_bit <= 5'h00;
      active <= '0;
      cmd_frame <= 1'b0;
      pdown_frame <= 1'b0;
      cmd_sent <= 1'b0;
      link_sdout <= 1'b0;
    end else begin
      cmd_sent <= 1'b0;
      case (state)
        ATX_IDLE, ATX_SEND: begin
          if (fr.bit_tick && state == ATX_SEND) begin
            link_sdout <= sr[SLOT_W-1];
          end else if (fr.bit_tick) begin
            link_sdout <= 1'b0;
          end
          if (fr.data_start) begin
            state <= ATX_SEND;
            active <= next_active;
            sr <= {tag, 4'h0};
            slot_idx <= 4'h0;
            slot_bit <= 5'h00;
            cmd_frame <= cmd_pend;
            pdown_frame <= cmd_pend && cmd_pdown;
            cmd_sent <= cmd_pend;
          end else if (state == ATX_SEND && fr.bit_tick) begin
            if (!last_bit) begin
              sr <= {sr[SLOT_W-2:0], 1'b0};
              slot_bit <= slot_bit + 5'h01;
            end else if (slot_idx == PDOWN_SLOT && pdown_frame) begin
              state <= ATX_OFF;
              link_sdout <= 1'b0;
            end else if (slot_idx == LAST_SLOT) begin
              state <= ATX_IDLE;
            end else begin
              slot_idx <= nslot;
              slot_bit <= 5'h00;
              sr <= slot_word(nslot, take && tx_valid);
            end
          end
        end
        ATX_OFF: begin
          link_sdout <= 1'b0;
          if (warm_active && warm_cnt == 7'(WARM_CYC - 1)) begin
            state <= ATX_IDLE;
          end
        end
        default: begin
          state <= ATX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Link pins
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link_sync <= 1'b0;
      link_bclk <= 1'b0;
    end else begin
      link_sync <= warm_active ||
        (fr.fsync && state != ATX_OFF);
      link_bclk <= bclk_int && state != ATX_OFF;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_warm_start;
    !warm_active ##1 warm_active;
  endsequence
  sequence s_warm_hold;
    link_sync [*8];
  endsequence

  a_warm_sync: assert property (@(posedge clk) disable iff (!rst_n)
    s_warm_start |=> s_warm_hold)
    else $error("warm reset sync not held high");
  a_warm_length: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(warm_active) |-> $past(warm_cnt) == 7'(WARM_CYC - 1))
    else $error("warm reset pulse length wrong");
  a_warm_clear: assert property (@(posedge clk) disable iff (!rst_n)
    warm_active && warm_cnt == 7'(WARM_CYC - 1) && !(wr &&
    addr == ADDR_LINK_SLOT && wdata[WARM_BIT]) |=> !link_slot[WARM_BIT])
    else $error("warm reset bit did not clear");
  a_pdown_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    state == ATX_OFF && $past(state == ATX_OFF) && !$past(warm_active)
    |-> !link_sdout && !link_bclk && !link_sync)
    else $error("link active while codec powered down");
  a_tag_id: assert property (@(posedge clk) disable iff (!rst_n)
    fr.data_start && state != ATX_OFF
    |=> sr[5:4] == $past(attached_device_number))
    else $error("slot 0 attached_device_number mismatch");
  a_fixed_slots: assert property (@(posedge clk) disable iff (!rst_n)
    fr.data_start && state != ATX_OFF && !vra_en |=> active == $past(slot_en))
    else $error("enabled slots not used in fixed rate frame");
  a_vra_hold: assert property (@(posedge clk) disable iff (!rst_n)
    fr.data_start && state != ATX_OFF && vra_en &&
    (tag_req & slot_en) != slot_en |=> active == '0)
    else $error("data sent before all enabled channels requested");
  a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
    rd && addr == ADDR_LINK_SLOT |=> (rdata & ~LINK_SLOT_MASK) == 32'h0)
    else $error("reserved bits read non-zero");
endmodule

// ---- rtl/atx_pkg.sv ----
// Operation
// - Delay first data bit by tx_dly bit clocks
// - Hold frame sync for width bit clocks, min one
// - Frame sync divides bit clock by period
// - Send attached device number in slot 0
// - Warm reset drives sync high one microsecond
// - Warm reset bit clears itself when done
// - One transmit enable per slot 3 to 12
// - Variable rate takes slot enables from TAG
// - Fixed rate sends enabled slots every frame
// - Variable rate sends when requests cover all enables
// - Withhold data until all enabled channels request
// - Bit clock divides master clock, min two
// - Power-down zeroes link outputs after slot 2
package atx_pkg;
  localparam logic [7:0] ADDR_BCLK_CFG = 8'h10;
  localparam logic [7:0] ADDR_TX_FRAME = 8'h18;
  localparam logic [7:0] ADDR_LINK_SLOT = 8'h1c;
  localparam logic [7:0] ADDR_TX_STATUS = 8'h2c;
  localparam logic [31:0] BCLK_MASK = 32'h0000_ffff;
  localparam logic [31:0] TX_FRAME_MASK = 32'h7fff_ffff;
  localparam logic [31:0] LINK_SLOT_MASK = 32'h0000_fff9;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam int DLY_LSB = 24;
  localparam int WIDTH_LSB = 16;
  localparam int ID_LSB = 14;
  localparam int WARM_BIT = 13;
  localparam int SLOT_EN_LSB = 3;
  localparam int VRA_BIT = 0;
  localparam int CLK_NS = 10;
  localparam int WARM_NS = 1000;
  localparam int WARM_CYC = (WARM_NS + CLK_NS - 1) / CLK_NS;
  localparam int NSLOT = 10;
  localparam int SLOT_W = 20;
  localparam int TAG_W = 16;
  localparam logic [3:0] FIRST_DATA_SLOT = 4'h3;
  localparam logic [3:0] LAST_SLOT = 4'hc;
  localparam logic [3:0] PDOWN_SLOT = 4'h2;
  localparam logic [4:0] TAG_LAST_BIT = 5'h0f;
  localparam logic [4:0] SLOT_LAST_BIT = 5'h13;
  typedef enum logic [2:0] {
    ATX_IDLE = 3'b001,
    ATX_SEND = 3'b010,
    ATX_OFF = 3'b100
  } atx_state_e;
endpackage

// ---- rtl/atx_frame_if.sv ----
`timescale 1ns/10ps
interface atx_frame_if;
  logic run;
  logic bit_tick;
  logic fsync;
  logic frame_start;
  logic data_start;
  modport div (input run, output bit_tick);
  modport gen (input run, input bit_tick, output fsync, output frame_start,
    output data_start);
  modport user (output run, input bit_tick, input fsync, input frame_start,
    input data_start);
endinterface

// ---- rtl/atx_bclk_div.sv ----
`timescale 1ns/10ps
module atx_bclk_div (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] div,
  atx_frame_if.div fr,
  output logic bclk
);
  logic [15:0] cnt;
  logic [15:0] div_eff;

  // Divisors below two would stall the link, so they act as two
  assign div_eff = (div < 16'h0002) ? 16'h0002 : div;
  // A divider lowered mid-count wraps at once instead of after 64K cycles
  assign fr.bit_tick = fr.run && (cnt >= div_eff - 16'h0001);

  always_ff @(posedge clk) begin
    if (!rst_n || !fr.run) begin
      cnt <= 16'h0000;
    end else if (fr.bit_tick) begin
      cnt <= 16'h0000;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end

  // Odd divisors leave the high phase one cycle short
  always_ff @(posedge clk) begin
    if (!rst_n || !fr.run) begin
      bclk <= 1'b0;
    end else begin
      bclk <= (cnt < (div_eff >> 1));
    end
  end
endmodule

// ---- rtl/atx_fsync_gen.sv ----
`timescale 1ns/10ps
module atx_fsync_gen (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] period,
  input wire logic [7:0] width,
  input wire logic [6:0] dly,
  atx_frame_if.gen fr
);
  logic [15:0] fcnt;
  logic [15:0] next_fcnt;
  logic [15:0] per_eff;
  logic [7:0] width_eff;

  assign per_eff = (period < 16'h0002) ? 16'h0002 : period;
  assign width_eff = (width == 8'h00) ? 8'h01 : width;
  assign next_fcnt = (fcnt >= per_eff - 16'h0001) ? 16'h0000 :
    fcnt + 16'h0001;

  always_ff @(posedge clk) begin
    if (!rst_n || !fr.run) begin
      fcnt <= per_eff - 16'h0001;
    end else if (fr.bit_tick) begin
      fcnt <= next_fcnt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !fr.run) begin
      fr.fsync <= 1'b0;
      fr.frame_start <= 1'b0;
      fr.data_start <= 1'b0;
    end else begin
      if (fr.bit_tick) begin
        fr.fsync <= (next_fcnt < {8'h00, width_eff});
      end
      fr.frame_start <= fr.bit_tick && (next_fcnt == 16'h0000);
      fr.data_start <= fr.bit_tick &&
        (next_fcnt == {9'h000, dly});
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [15:0] since;
  always_ff @(posedge clk) begin
    if (!rst_n || !fr.run || fr.frame_start) begin
      since <= 16'h0000;
    end else if (fr.bit_tick) begin
      since <= since + 16'h0001;
    end
  end

  // A period write mid-frame changes that frame's length; judge only whole frames
  logic [15:0] period_q;
  logic per_settled;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      period_q <= 16'h0000;
      per_settled <= 1'b0;
    end else begin
      period_q <= period;
      if (!fr.run || period_q != period) begin
        per_settled <= 1'b0;
      end else if (fr.frame_start) begin
        per_settled <= 1'b1;
      end
    end
  end

  a_data_delay: assert property (@(posedge clk) disable iff (!rst_n)
    fr.data_start && !fr.frame_start && fr.run
    |-> since == {9'h000, $past(dly)})
    else $error("first data bit not at programmed delay");
  a_sync_width: assert property (@(posedge clk) disable iff (!rst_n)
    fr.frame_start |-> fr.fsync)
    else $error("frame sync not active at frame start");
  a_sync_drop: assert property (@(posedge clk) disable iff (!rst_n)
    $past(fr.bit_tick) && !fr.frame_start &&
    since >= {8'h00, $past(width_eff)} |-> !fr.fsync)
    else $error("frame sync longer than programmed width");
  a_frame_period: assert property (@(posedge clk) disable iff (!rst_n)
    fr.frame_start && per_settled
    |-> $past(since) == $past(per_eff) - 16'h0001)
    else $error("frame period differs from programmed divider");
endmodule

// ---- sim/atx_codec_model.sv ----
`timescale 1ns/10ps
module atx_codec_model
  import atx_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_bclk,
  input wire logic link_sync,
  input wire logic link_sdout,
  input wire logic [6:0] dly,
  input wire logic [NSLOT-1:0] req_set,
  output logic rx_tag_valid,
  output logic [NSLOT-1:0] rx_tag_req,
  output logic [TAG_W-1:0] tag_seen
);
  logic bclk_q;
  logic sync_q;
  logic [8:0] fall_cnt;
  logic [8:0] first;
  logic [TAG_W-1:0] shift;

  // Sync rises on a falling edge, so the count already stands at the delay
  assign first = {2'b00, dly};

  // ----------------------------------------
  // Codec side: requests and slot 0 capture
  // ----------------------------------------
  // Bits are taken on the falling bit clock edge, mid-bit, as a codec would
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bclk_q <= 1'b0;
      sync_q <= 1'b0;
      fall_cnt <= 9'h0;
      shift <= 16'h0;
      tag_seen <= 16'h0;
      rx_tag_valid <= 1'b0;
      rx_tag_req <= '0;
    end else begin
      bclk_q <= link_bclk;
      sync_q <= link_sync;
      rx_tag_valid <= 1'b0;
      // Outside a request the lines carry junk, never the last value
      rx_tag_req <= ~req_set;
      if (link_sync && !sync_q) begin
        fall_cnt <= 9'h0;
        rx_tag_valid <= 1'b1;
        rx_tag_req <= req_set;
      end else if (bclk_q && !link_bclk) begin
        fall_cnt <= fall_cnt + 9'h1;
        if (fall_cnt >= first && fall_cnt < first + 9'h10) begin
          shift <= {shift[14:0], link_sdout};
        end
        if (fall_cnt == first + 9'hf) begin
          tag_seen <= {shift[14:0], link_sdout};
        end
      end
    end
  end
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/10ps
module testbench
  import atx_pkg::*;
;
  logic clk;
  logic rst_n;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [SLOT_W-1:0] tx_data = 20'h01178;
  logic tx_valid;
  logic tx_ready;
  logic rx_tag_valid;
  logic [NSLOT-1:0] rx_tag_req;
  logic [NSLOT-1:0] req_set;
  logic cmd_req;
  logic cmd_read;
  logic [6:0] cmd_index;
  logic [15:0] cmd_wdata;
  logic cmd_pdown;
  logic cmd_sent;
  logic link_bclk;
  logic link_sync;
  logic link_sdout;
  logic [6:0] dly;
  logic [15:0] lfsr;
  logic [TAG_W-1:0] tag_seen;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int run = 0;
  int last_run = 0;
  int readies = 0;
  int sents = 0;

  atx_top u_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_tag_valid(rx_tag_valid),
    .rx_tag_req(rx_tag_req), .cmd_req(cmd_req), .cmd_read(cmd_read),
    .cmd_index(cmd_index), .cmd_wdata(cmd_wdata), .cmd_pdown(cmd_pdown),
    .cmd_sent(cmd_sent), .link_bclk(link_bclk), .link_sync(link_sync),
    .link_sdout(link_sdout));

  atx_codec_model u_codec (.clk(clk), .rst_n(rst_n), .link_bclk(link_bclk),
    .link_sync(link_sync), .link_sdout(link_sdout), .dly(dly),
    .req_set(req_set), .rx_tag_valid(rx_tag_valid),
    .rx_tag_req(rx_tag_req), .tag_seen(tag_seen));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  function automatic logic [15:0] rnd();
    lfsr = lfsr_next(lfsr);
    return lfsr;
  endfunction

  // Slot 3 rides in the upper tag bit, so the enable set appears reversed
  function automatic logic [9:0] rev10(input logic [9:0] v);
    logic [9:0] r;
    for (int i = 0; i < 10; i++) begin
      r[i] = v[9 - i];
    end
    return r;
  endfunction

  task automatic check(input string name, input logic [31:0] exp,
    input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic sync_edge();
    int n;
    n = 0;
    do begin
      tick();
      n++;
    end while (link_sync !== 1'b0 && n < 9000);
    while (link_sync !== 1'b1 && n < 9000) begin
      tick();
      n++;
    end
    if (n >= 9000) begin
      check("sync_wait", 32'h1, 32'h0);
    end
  endtask

  task automatic measure(output int hi, output int per);
    sync_edge();
    hi = 0;
    per = 0;
    while (link_sync === 1'b1 && per < 9000) begin
      tick();
      hi++;
      per++;
    end
    while (link_sync !== 1'b1 && per < 9000) begin
      tick();
      per++;
    end
  endtask

  task automatic frame_check(input logic [9:0] en, input logic [1:0] id);
    int r0;
    sync_edge();
    r0 = readies;
    sync_edge();
    check("tag_id", {30'h0, id}, {30'h0, tag_seen[1:0]});
    check("tag_slots", {22'h0, rev10(en)}, {22'h0, tag_seen[12:3]});
    check("slot_reads", $countones(en), readies - r0);
  endtask

  // ----------------------------------------
  // Monitors, sample source and hang limit
  // ----------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    run <= link_sync ? run + 1 : 0;
    if (!link_sync && run != 0) begin
      last_run <= run;
    end
    if (tx_ready) begin
      readies <= readies + 1;
      tx_data <= {4'h0, lfsr_next(tx_data[15:0])};
    end
    if (cmd_sent) begin
      sents <= sents + 1;
    end
    if (cyc == 60000) begin
      fail_count++;
      close_out();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] d;
    logic [31:0] lnk;
    logic [31:0] frm;
    logic act;
    int hi;
    int per;
    int n;
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h0;
    wdata = 32'h0;
    tx_valid = 1'b0;
    cmd_req = 1'b0;
    cmd_read = 1'b0;
    cmd_index = 7'h0;
    cmd_wdata = 16'h0;
    cmd_pdown = 1'b0;
    req_set = 10'h0;
    dly = 7'h0;
    lfsr = 16'h1178;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    tx_valid <= 1'b1;
    rd_reg(ADDR_TX_FRAME, d);
    check("frame_rst", REG_RESET, d);
    rd_reg(ADDR_LINK_SLOT, d);
    check("slot_rst", REG_RESET, d);
    rd_reg(8'h40, d);
    check("unmapped", 32'h0, d);
    repeat (4) begin
      frm = {rnd(), rnd() & 16'h3f};
      wr_reg(ADDR_TX_FRAME, frm);
      rd_reg(ADDR_TX_FRAME, d);
      check("frame_cfg", frm & TX_FRAME_MASK, d);
      lnk = {rnd(), rnd()} & ~32'h2000;
      wr_reg(ADDR_LINK_SLOT, lnk);
      rd_reg(ADDR_LINK_SLOT, d);
      check("slot_cfg", lnk & LINK_SLOT_MASK, d);
    end
    // Period 1 and width 0 are the illegal corners, clamped to 2 and 1
    for (int k = 0; k < 4; k++) begin
      logic [15:0] dv;
      logic [15:0] pr;
      logic [7:0] wd;
      dv = 16'(2 + k);
      pr = (k == 0) ? 16'h1 : 16'h3 + (rnd() & 16'h1f);
      wd = (k < 2) ? 8'(1 - k) : 8'h1 + 8'(rnd() & 16'h1);
      wr_reg(ADDR_BCLK_CFG, {16'h0, dv});
      wr_reg(ADDR_TX_FRAME, {8'h0, wd, pr});
      measure(hi, per);
      measure(hi, per);
      check("sync_high", (wd == 0 ? 1 : wd) * dv, hi);
      check("sync_period", (pr < 2 ? 2 : pr) * dv, per);
    end
    wr_reg(ADDR_BCLK_CFG, 32'h2);
    dly = 7'(rnd() & 16'hf);
    wr_reg(ADDR_TX_FRAME, {1'b0, dly, 8'h1, 16'd300});
    // Fixed rate twice, then variable rate covered and one slot short
    for (int k = 0; k < 4; k++) begin
      logic [9:0] en;
      logic [9:0] rq;
      logic [1:0] id;
      logic [9:0] ex;
      en = 10'(rnd()) | 10'h1;
      id = 2'(rnd());
      rq = (k == 3) ? en & ~10'h1 : en | 10'(rnd());
      req_set = rq;
      ex = (k < 2) ? en : ((k == 2) ? rq : 10'h000);
      wr_reg(ADDR_LINK_SLOT, {16'h0, id, 1'b0, en, 3'(k >= 2)});
      sync_edge();
      frame_check(ex, id);
    end
    @(posedge clk);
    cmd_index <= 7'(rnd());
    cmd_wdata <= rnd();
    cmd_pdown <= 1'b1;
    cmd_req <= 1'b1;
    @(posedge clk);
    cmd_req <= 1'b0;
    n = 0;
    while (sents == 0 && n < 2000) begin
      tick();
      n++;
    end
    check("cmd_sent", 32'h1, sents);
    repeat (200) tick();
    act = 1'b0;
    repeat (600) begin
      tick();
      act = act | link_bclk | link_sync | link_sdout;
    end
    check("link_quiet", 32'h0, {31'h0, act});
    rd_reg(ADDR_TX_STATUS, d);
    check("pdown_status", 32'h0000_0800, d);
    cmd_pdown <= 1'b0;
    lnk = {16'h0, 2'h0, 1'b0, 10'h3ff, 3'h0};
    wr_reg(ADDR_LINK_SLOT, lnk | 32'h2000);
    wr_reg(ADDR_LINK_SLOT, lnk);
    rd_reg(ADDR_LINK_SLOT, d);
    check("warm_busy", lnk | 32'h2000, d);
    n = 0;
    while (link_sync === 1'b1 && n < 300) begin
      tick();
      n++;
    end
    tick();
    check("warm_len", WARM_CYC, last_run);
    rd_reg(ADDR_LINK_SLOT, d);
    check("warm_done", lnk, d);
    frame_check(10'h3ff, 2'h0);
    close_out();
  end
endmodule
